/* rleh_fabric_model.sv */
module rleh_fabric_model (
   input wire logic clk_sys,
   input wire logic [15:0] egress_disabled,
   output logic [15:0] egress_buf_full
);
   timeunit 1ns;
   timeprecision 1ns;
   // a disabled egress drains nothing, so its output buffers fill a cycle later
   always @(posedge clk_sys) begin
      egress_buf_full <= egress_disabled;
   end
endmodule // rleh_fabric_model

/* rleh_lookup.sv */
module rleh_lookup #(
   parameter int PORT_ID = 0,
   parameter int TIMEOUT = rleh_pkg::FABRIC_TO_CYC
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic port_shutdown,
   input wire logic [rleh_pkg::PORT_W-1:0] port_total,
   input wire logic [rleh_pkg::PORT_W-1:0] default_port,
   input wire logic [15:0] egress_shutdown,
   input wire logic [15:0] egress_disabled,
   input wire logic [15:0] egress_disconnected,
   input wire logic [15:0] egress_buf_full,
   input wire logic pw_en,
   input wire logic int_en,
   input wire logic tfa_pw_en,
   input wire logic tfa_int_en,
   input wire logic err_clear,
   input wire logic tfa_clear,
   input wire logic pkt_valid,
   output logic pkt_ready,
   input wire rleh_pkg::rleh_pkt_t pkt_in,
   output logic fwd_valid,
   output logic [rleh_pkg::PORT_W-1:0] fwd_port,
   output logic [31:0] fwd_header,
   output logic pkt_dropped,
   input wire rleh_pkg::rleh_tacc_t tacc,
   output logic [rleh_pkg::PORT_W-1:0] tacc_rdata,
   input wire logic [11:0] reg_ofs,
   input wire logic [31:0] reg_live_val,
   output logic [31:0] reg_rdata,
   output logic impl_specific_error_flag,
   output logic [31:0] capt_header,
   output logic [rleh_pkg::PORT_W-1:0] par_err_port,
   output logic par_err_valid,
   output logic transfer_fail_ack,
   output logic tfa_status,
   output logic port_write_req,
   output logic irq
);
   import rleh_pkg::*;

   // entry = parity bit + port number
   logic [PORT_W:0] lut_mem [LUT_DEPTH];
   rleh_state_t state_r;
   rleh_pkt_t pkt_r;
   logic [PORT_W:0] entry_r;
   logic [7:0] to_cnt_r;
   logic tacc_oor;
   logic [PORT_W-1:0] eg_port;
   logic eg_unmapped;
   logic dflt_unmapped;
   logic par_bad;
   logic lut_err;
   logic unm_err;
   // blocked egress is latched on entry to the wait, so the timeout watches the right buffers
   logic [PORT_W-1:0] wait_port_r;
   // a flag set by a plain fallback must not stop the first real error header being kept
   logic capt_held_r;

   assign tacc_oor = |tacc.dest_id[DEST_W-1:LUT_IDX_W];
   assign pkt_ready = (state_r == ST_IDLE);

   always_ff @(posedge clk_sys) begin
      // broadcast writes skip a shut-down port silently
      if (tacc.we && !tacc_oor && !(tacc.bcast && port_shutdown)) begin
         lut_mem[tacc.dest_id[LUT_IDX_W-1:0]] <= {^tacc.wdata, tacc.wdata};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         tacc_rdata <= '0;
      end else if (tacc.re) begin
         if (tacc_oor) begin
            tacc_rdata <= OOR_READ_VAL;
         end else begin
            tacc_rdata <= lut_mem[tacc.dest_id[LUT_IDX_W-1:0]][PORT_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         reg_rdata <= '0;
      end else if (port_shutdown && reg_ofs != OFS_KEEP_A && reg_ofs != OFS_KEEP_B) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= reg_live_val;
      end
   end

   // packet lookup: entry is read (and parity checked) only per arriving packet
   assign par_bad = ^entry_r;
   assign dflt_unmapped = (default_port > port_total);
   always_comb begin
      eg_unmapped = (entry_r[PORT_W-1:0] > port_total) || pkt_r.dest_id[DEST_W-1:LUT_IDX_W] != '0;
      eg_port = eg_unmapped ? default_port : entry_r[PORT_W-1:0];
   end
   assign unm_err = (state_r == ST_LOOK) && !par_bad && eg_unmapped;
   assign lut_err = (state_r == ST_LOOK) && (par_bad || (eg_unmapped && dflt_unmapped));

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state_r <= ST_IDLE;
         pkt_r <= '0;
         entry_r <= '0;
         wait_port_r <= '0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (pkt_valid) begin
                  pkt_r <= pkt_in;
                  entry_r <= lut_mem[pkt_in.dest_id[LUT_IDX_W-1:0]];
                  state_r <= ST_LOOK;
               end
            end
            ST_LOOK: begin
               wait_port_r <= eg_port;
               if (!par_bad && !(eg_unmapped && dflt_unmapped) && egress_disabled[eg_port]
                   && !egress_shutdown[eg_port] && !egress_disconnected[eg_port]) begin
                  state_r <= ST_WAIT;
               end else begin
                  state_r <= ST_IDLE;
               end
            end
            ST_WAIT: begin
               if (transfer_fail_ack) begin
                  state_r <= ST_IDLE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         fwd_valid <= 1'b0;
         fwd_port <= '0;
         fwd_header <= '0;
         pkt_dropped <= 1'b0;
      end else begin
         fwd_valid <= 1'b0;
         pkt_dropped <= 1'b0;
         if (state_r == ST_LOOK) begin
            if (lut_err || egress_shutdown[eg_port] || egress_disconnected[eg_port]) begin
               pkt_dropped <= 1'b1;
            end else if (!egress_disabled[eg_port]) begin
               fwd_valid <= 1'b1;
               fwd_port <= eg_port;
               fwd_header <= pkt_r.header;
            end
         end else if (state_r == ST_WAIT && transfer_fail_ack) begin
            pkt_dropped <= 1'b1;
         end
      end
   end

   // timeout counts only while the blocked port's buffers are full
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         to_cnt_r <= '0;
         transfer_fail_ack <= 1'b0;
      end else begin
         transfer_fail_ack <= 1'b0;
         if (state_r != ST_WAIT || transfer_fail_ack) begin
            to_cnt_r <= '0;
         end else if (egress_buf_full[wait_port_r]) begin
            if (to_cnt_r == 8'(TIMEOUT - 1)) begin
               transfer_fail_ack <= 1'b1;
            end else begin
               to_cnt_r <= to_cnt_r + 8'h01;
            end
         end
      end
   end

   // set wins over clear; first header held until cleared
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         impl_specific_error_flag <= 1'b0;
         capt_header <= '0;
         capt_held_r <= 1'b0;
         par_err_port <= '0;
         par_err_valid <= 1'b0;
      end else begin
         if (lut_err || unm_err) begin
            impl_specific_error_flag <= 1'b1;
         end else if (err_clear) begin
            impl_specific_error_flag <= 1'b0;
         end
         if (lut_err && (!capt_held_r || err_clear)) begin
            capt_header <= pkt_r.header;
            capt_held_r <= 1'b1;
         end else if (err_clear) begin
            capt_held_r <= 1'b0;
         end
         if (lut_err && par_bad) begin
            par_err_port <= PORT_W'(PORT_ID);
            par_err_valid <= 1'b1;
         end else if (err_clear) begin
            par_err_valid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         tfa_status <= 1'b0;
         port_write_req <= 1'b0;
         irq <= 1'b0;
      end else begin
         if (transfer_fail_ack) begin
            tfa_status <= 1'b1;
         end else if (tfa_clear) begin
            tfa_status <= 1'b0;
         end
         port_write_req <= (lut_err && pw_en) || (transfer_fail_ack && tfa_pw_en);
         irq <= (impl_specific_error_flag && int_en) || (tfa_status && tfa_int_en);
      end
   end

   property p_oor_read;
      @(posedge clk_sys) disable iff (!nrst)
      tacc.re && tacc_oor |=> tacc_rdata == OOR_READ_VAL;
   endproperty
   a_oor_read: assert property (p_oor_read) else $error("oor read not 0xf");

   property p_shut_read;
      @(posedge clk_sys) disable iff (!nrst)
      port_shutdown && reg_ofs != OFS_KEEP_A && reg_ofs != OFS_KEEP_B |=> reg_rdata == '0;
   endproperty
   a_shut_read: assert property (p_shut_read) else $error("shut port read nonzero");

   property p_lut_err_flag;
      @(posedge clk_sys) disable iff (!nrst)
      lut_err |=> impl_specific_error_flag && pkt_dropped && !fwd_valid;
   endproperty
   a_lut_err_flag: assert property (p_lut_err_flag) else $error("lut error not handled");

   property p_par_port;
      @(posedge clk_sys) disable iff (!nrst)
      lut_err && par_bad |=> par_err_valid && par_err_port == PORT_W'(PORT_ID);
   endproperty
   a_par_port: assert property (p_par_port) else $error("parity port not stored");

   property p_flag_hold;
      @(posedge clk_sys) disable iff (!nrst)
      impl_specific_error_flag && !err_clear |=> impl_specific_error_flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("error flag lost");

   property p_tfa_full;
      @(posedge clk_sys) disable iff (!nrst)
      transfer_fail_ack |-> $past(egress_buf_full[wait_port_r]) && $past(state_r) == ST_WAIT;
   endproperty
   a_tfa_full: assert property (p_tfa_full) else $error("tfa without full buffers");

   property p_tfa_status;
      @(posedge clk_sys) disable iff (!nrst)
      transfer_fail_ack |=> tfa_status && pkt_dropped && state_r == ST_IDLE;
   endproperty
   a_tfa_status: assert property (p_tfa_status) else $error("tfa status not set");

   property p_shut_drop;
      @(posedge clk_sys) disable iff (!nrst)
      state_r == ST_LOOK && egress_shutdown[eg_port] |=> !fwd_valid && pkt_dropped;
   endproperty
   a_shut_drop: assert property (p_shut_drop) else $error("shut port forwarded");

   property p_disc_drop;
      @(posedge clk_sys) disable iff (!nrst)
      state_r == ST_LOOK && egress_disconnected[eg_port] |=> !fwd_valid && pkt_dropped;
   endproperty
   a_disc_drop: assert property (p_disc_drop) else $error("disconnected port forwarded");

   property p_dflt_route;
      @(posedge clk_sys) disable iff (!nrst)
      state_r == ST_LOOK && eg_unmapped && !dflt_unmapped && !par_bad
         && !egress_shutdown[eg_port] && !egress_disconnected[eg_port]
         && !egress_disabled[eg_port]
      |=> fwd_valid && fwd_port == $past(default_port) && impl_specific_error_flag;
   endproperty
   a_dflt_route: assert property (p_dflt_route) else $error("fallback not to default");

   property p_pw_gate;
      @(posedge clk_sys) disable iff (!nrst)
      lut_err |=> port_write_req == $past(pw_en);
   endproperty
   a_pw_gate: assert property (p_pw_gate) else $error("port write not per enable");

   property p_capt;
      @(posedge clk_sys) disable iff (!nrst)
      lut_err && !capt_held_r |=> capt_header == $past(pkt_r.header);
   endproperty
   a_capt: assert property (p_capt) else $error("error header not captured");
endmodule // rleh_lookup

/* rleh_pkg.sv */
package rleh_pkg;
   localparam int PORT_W = 4;
   localparam int DEST_W = 16;
   localparam int LUT_IDX_W = 9;
   localparam int LUT_DEPTH = 512;
   localparam logic [PORT_W-1:0] OOR_READ_VAL = 4'hf;
   localparam logic [PORT_W-1:0] DFLT_PORT_RST = 4'hf;
   localparam logic [11:0] OFS_KEEP_A = 12'h158;
   localparam logic [11:0] OFS_KEEP_B = 12'h15c;
   localparam int FABRIC_TO_CYC = 64;
   localparam logic [7:0] FABRIC_TO_CNT = 8'(FABRIC_TO_CYC);

   typedef struct packed {
      logic [DEST_W-1:0] dest_id;
      logic [31:0] header;
   } rleh_pkt_t;

   typedef struct packed {
      logic we;
      logic re;
      logic bcast;
      logic [DEST_W-1:0] dest_id;
      logic [PORT_W-1:0] wdata;
   } rleh_tacc_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOOK = 2'b01,
      ST_WAIT = 2'b11
   } rleh_state_t;
endpackage

/* test_route_lookup_error_handler.sv */
module test_route_lookup_error_handler;
   import rleh_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 0, nrst = 0, port_shutdown = 0, pw_en = 1, int_en = 1;
   logic err_clear = 0, tfa_clear = 0, pkt_valid = 0;
   logic [3:0] default_port = 4'h3;
   logic [15:0] eg_shut = 16'h0, eg_dis = 16'h0, eg_disc = 16'h0, eg_full;
   rleh_pkt_t pkt_in = '0;
   rleh_tacc_t tacc = '0;
   logic [11:0] reg_ofs = 12'h0;
   logic [31:0] live = 32'h5a5a_0001;
   logic pkt_ready, fwd_valid, pkt_dropped, flag, tfa, tfa_status, pw_req, irq;
   logic [3:0] fwd_port, tacc_rdata;
   logic [31:0] reg_rdata, capt_header, fwd_header, gh;
   logic [3:0] ptot = 4'h7;
   logic perr_v, tfa_en = 1;
   logic sf, sd, sp, st;
   logic [3:0] gp;
   int fails = 0, check_count = 0;
   always #25 clk_sys = ~clk_sys;
   rleh_fabric_model fab_u (.clk_sys(clk_sys), .egress_disabled(eg_dis),
      .egress_buf_full(eg_full));
   rleh_lookup #(.TIMEOUT(4)) dut_u (.clk_sys(clk_sys), .nrst(nrst),
      .port_shutdown(port_shutdown), .port_total(ptot), .default_port(default_port),
      .egress_shutdown(eg_shut), .egress_disabled(eg_dis), .egress_disconnected(eg_disc),
      .egress_buf_full(eg_full), .pw_en(pw_en), .int_en(int_en), .tfa_pw_en(tfa_en),
      .tfa_int_en(tfa_en), .err_clear(err_clear), .tfa_clear(tfa_clear),
      .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt_in(pkt_in),
      .fwd_valid(fwd_valid), .fwd_port(fwd_port), .fwd_header(fwd_header),
      .pkt_dropped(pkt_dropped),
      .tacc(tacc), .tacc_rdata(tacc_rdata), .reg_ofs(reg_ofs), .reg_live_val(live),
      .reg_rdata(reg_rdata), .impl_specific_error_flag(flag), .capt_header(capt_header),
      .par_err_port(), .par_err_valid(perr_v), .transfer_fail_ack(tfa),
      .tfa_status(tfa_status), .port_write_req(pw_req), .irq(irq));
   task automatic close_out;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one packet, then watch a fixed window long enough for the fabric timeout path
   task automatic send(input logic [15:0] d, input logic [31:0] h);
      @(posedge clk_sys);
      pkt_in <= '{dest_id: d, header: h};
      pkt_valid <= 1'b1;
      @(posedge clk_sys);
      pkt_valid <= 1'b0;
      {sf, sd, sp, st} = 4'h0;
      repeat (40) begin
         @(negedge clk_sys);
         if (fwd_valid === 1'b1) begin
            sf = 1'b1;
            gp = fwd_port;
            gh = fwd_header;
         end
         if (pkt_dropped === 1'b1) sd = 1'b1;
         if (pw_req === 1'b1) sp = 1'b1;
         if (tfa === 1'b1) st = 1'b1;
      end
   endtask
   task automatic tab(input logic w, input logic r, input logic b, input logic [15:0] d,
      input logic [3:0] v);
      @(posedge clk_sys);
      tacc <= '{we: w, re: r, bcast: b, dest_id: d, wdata: v};
      @(posedge clk_sys);
      tacc <= '0;
      @(negedge clk_sys);
   endtask
   task automatic rd_reg(input logic [11:0] o);
      @(posedge clk_sys);
      reg_ofs <= o;
      @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task automatic clr;
      @(posedge clk_sys);
      err_clear <= 1'b1;
      tfa_clear <= 1'b1;
      @(posedge clk_sys);
      err_clear <= 1'b0;
      tfa_clear <= 1'b0;
   endtask
   initial begin
      #1000000;
      fails++;
      close_out();
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      tab(1, 0, 0, 16'h1, 4'h2);
      tab(1, 0, 0, 16'h2, 4'h9);
      tab(1, 0, 0, 16'h58, 4'h5);
      tab(1, 0, 0, 16'h258, 4'h1);
      tab(0, 1, 0, 16'h258, 4'h0);
      chk("oor_rd", tacc_rdata, OOR_READ_VAL);
      tab(0, 1, 0, 16'h58, 4'h0);
      chk("oor_wr", tacc_rdata, 4'h5);
      send(16'h1, 32'h1111_0001);
      chk("mapped", {sf, gp, flag}, {1'b1, 4'h2, 1'b0});
      chk("mapped_hdr", gh, 32'h1111_0001);
      send(16'h2, 32'h1111_0002);
      chk("dflt", {sf, gp, flag}, {1'b1, 4'h3, 1'b1});
      clr();
      default_port <= 4'hc;
      send(16'h2, 32'habcd_0002);
      chk("unm_drop", {sd, sf, flag}, 3'b101);
      chk("unm_capt", capt_header, 32'habcd_0002);
      chk("unm_ntf", {sp, irq}, 2'b11);
      chk("unm_par", perr_v, 1'b0);
      send(16'h2, 32'hffff_0003);
      chk("hold", {flag, capt_header}, {1'b1, 32'habcd_0002});
      clr();
      pw_en <= 1'b0;
      send(16'h2, 32'h2222_0004);
      chk("pw_off", {sp, flag}, 2'b01);
      clr();
      default_port <= 4'h3;
      eg_shut <= 16'h0004;
      send(16'h1, 32'h3333_0005);
      chk("shut", {sd, sf, flag}, 3'b100);
      @(posedge clk_sys);
      eg_shut <= 16'h0;
      eg_disc <= 16'h0004;
      send(16'h1, 32'h3333_0006);
      chk("disc", {sd, sf, flag}, 3'b100);
      @(posedge clk_sys);
      eg_disc <= 16'h0;
      send(16'h1, 32'h3333_0007);
      chk("relink", {sf, gp}, {1'b1, 4'h2});
      @(posedge clk_sys);
      eg_dis <= 16'h0004;
      send(16'h1, 32'h3333_0008);
      chk("tfa", {st, tfa_status}, 2'b11);
      chk("tfa_drop", {sd, sf}, 2'b10);
      chk("tfa_ntf", {sp, irq}, 2'b11);
      chk("tfa_rdy", pkt_ready, 1'b1);
      clr();
      tfa_en <= 1'b0;
      send(16'h1, 32'h3333_0009);
      chk("tfa_off", {st, sp, irq, tfa_status}, 4'b1001);
      @(posedge clk_sys);
      eg_dis <= 16'h0;
      port_shutdown <= 1'b1;
      tab(1, 0, 1, 16'h1, 4'h6);
      rd_reg(OFS_KEEP_A);
      chk("keep_a", reg_rdata, live);
      rd_reg(OFS_KEEP_B);
      chk("keep_b", reg_rdata, live);
      rd_reg(12'h100);
      chk("shut_rd", reg_rdata, 32'h0);
      @(posedge clk_sys);
      port_shutdown <= 1'b0;
      rd_reg(12'h100);
      chk("live_rd", reg_rdata, live);
      tab(0, 1, 0, 16'h1, 4'h0);
      chk("bc_shut", {tacc_rdata, flag}, {4'h2, 1'b0});
      @(posedge clk_sys);
      ptot <= 4'h1;
      default_port <= 4'h0;
      send(16'h1, 32'h4444_000a);
      chk("ptot", {sf, gp, flag}, {1'b1, 4'h0, 1'b1});
      close_out();
   end
endmodule // test_route_lookup_error_handler
